//--- include/bvc_pkg.sv
package bvc_pkg;
    // register offsets
    localparam logic [3:0] OFS_LOW_SEL = 4'h0;
    localparam logic [3:0] OFS_HIGH_SEL = 4'h1;
    localparam logic [3:0] OFS_CTL_ONE = 4'h2;
    localparam logic [3:0] OFS_PRODUCT = 4'h3;
    localparam logic [3:0] OFS_REVISION = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h5;
    // reset values
    localparam logic [7:0] RST_SETPOINT = 8'h14;
    localparam logic [7:0] RST_CTL_ONE = 8'h92;
    // control and status field positions
    localparam int BIT_DISCHARGE = 7;
    localparam int BIT_SLEW_HI = 6;
    localparam int BIT_SLEW_LO = 4;
    localparam int BIT_SOFT_RESTART = 2;
    localparam int BIT_HIGH_MODE = 1;
    localparam int BIT_LOW_MODE = 0;
    localparam int BIT_RESTART_SEEN = 2;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hF3;
    // identity fields, values arbitrary
    localparam logic [5:0] PRODUCT_FIXED = 6'h2A;
    localparam logic [1:0] PRODUCT_CODE = 2'h2;
    localparam logic [5:0] REVISION_FIXED = 6'h00;
    localparam logic [1:0] REVISION_CODE = 2'h3;
    // serial address 1010000
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // timing: one 5 mV step at 40 mV/us lasts 125 ns
    localparam int CLK_PERIOD_PS = 50000;
    localparam int RISE_STEP_PS = 125000;

    typedef enum logic [3:0] {
        BVC_IDLE,
        BVC_ADDR,
        BVC_ACK_ADDR,
        BVC_REG,
        BVC_ACK_REG,
        BVC_WDATA,
        BVC_ACK_WDATA,
        BVC_RDATA,
        BVC_ACK_RDATA
    } bvc_state_e;

    // cycles per 5 mV step; each slew code halves the rate, rounded up
    function automatic logic [9:0] step_cycles(input logic [2:0] code);
        int t;
        t = ((RISE_STEP_PS << code) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return 10'(t);
    endfunction
endpackage

//--- include/bvc_ramp_if.sv
`timescale 1ns/1ps
interface bvc_ramp_if;
    logic [7:0] target_code;
    logic [2:0] rise_slew_code;
    logic [7:0] applied_code;
    logic rising;
    modport ctl (output target_code, output rise_slew_code, input applied_code, input rising);
    modport ramp (input target_code, input rise_slew_code, output applied_code, output rising);
endinterface

//--- verilog/bvc_ramp.sv
`timescale 1ns/1ps
module bvc_ramp (
    input wire logic clk,
    input wire logic rst_n,
    bvc_ramp_if.ramp rif
);
    logic [7:0] applied_q;
    logic [9:0] timer_q;
    logic rising_q;

    assign rif.applied_code = applied_q;
    assign rif.rising = rising_q;

    // upward changes step 5 mV per slew interval, downward changes jump
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied_q <= bvc_pkg::RST_SETPOINT;
            timer_q <= 10'h000;
            rising_q <= 1'b0;
        end else if (rif.target_code > applied_q) begin
            rising_q <= 1'b1;
            if (timer_q + 10'h001 >= bvc_pkg::step_cycles(rif.rise_slew_code)) begin
                applied_q <= applied_q + 8'h01;
                timer_q <= 10'h000;
            end else begin
                timer_q <= timer_q + 10'h001;
            end
        end else begin
            rising_q <= 1'b0;
            applied_q <= rif.target_code;
            timer_q <= 10'h000;
        end
    end
endmodule

//--- verilog/bvc_top.sv
// Function
// - pin low selects low set point, 0.5 V plus code times 5 mV.
// - pin high selects high set point, same code-to-voltage mapping.
// - both set points reset to code 0x14, i.e. 0.600 V.
// - control register resets to 0x92: discharge on, slew 001, modes 1 and 0.
// - rising changes ramp at rate from bits 6:4, 40 down to 0.3125 mV/us.
// - writing 1 to control bit 2 resets registers; bit then clears itself.
// - pin high: bit 1 zero gives auto PWM/PFM, one gives continuous PWM.
// - bit 0 holds the mode for pin low, same coding.
// - product identity read-only: code in bits 1:0, fixed bits 7:2.
// - revision identity read-only: code in bits 1:0, zero bits above.
// - soft reset sets status bit 2, which clears when the status register is read.
`timescale 1ns/1ps
module bvc_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_b,
    input wire logic level_sel,
    output logic [7:0] applied_code,
    output logic rise_active,
    output logic cont_pwm,
    output logic discharge_en,
    output logic restart_seen
);
    logic rst_meta_q;
    logic rst_n_q;
    logic scl_q;
    logic sda_q;
    bvc_pkg::bvc_state_e state_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [3:0] ptr_q;
    logic rd_q;
    logic drive_low_q;
    logic wr_stb_q;
    logic [3:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic status_read_q;
    logic [7:0] low_setpoint_code_q;
    logic [7:0] high_setpoint_code_q;
    logic [7:0] ctl_q;
    logic soft_restart_trigger_q;
    logic restart_seen_q;
    logic cont_pwm_q;
    logic discharge_q;
    logic [7:0] applied_q;
    logic rising_q;
    logic sda_out_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic soft_reset;
    logic [7:0] rd_val;

    bvc_ramp_if rif ();

    bvc_ramp u_ramp (
        .clk(clk),
        .rst_n(rst_n_q),
        .rif(rif.ramp)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    function automatic logic [7:0] read_reg(
        input logic [3:0] a,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input logic [7:0] ctl,
        input logic trig,
        input logic seen
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            bvc_pkg::OFS_LOW_SEL: v = lo;
            bvc_pkg::OFS_HIGH_SEL: v = hi;
            bvc_pkg::OFS_CTL_ONE: begin
                v = ctl & bvc_pkg::CTL_WRITE_MASK;
                v[bvc_pkg::BIT_SOFT_RESTART] = trig;
            end
            bvc_pkg::OFS_PRODUCT: v = {bvc_pkg::PRODUCT_FIXED, bvc_pkg::PRODUCT_CODE};
            bvc_pkg::OFS_REVISION: v = {bvc_pkg::REVISION_FIXED, bvc_pkg::REVISION_CODE};
            bvc_pkg::OFS_STATUS: v[bvc_pkg::BIT_RESTART_SEEN] = seen;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // bus line sampling and edge detection
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_seen = scl_i & scl_q & ~sda_q & sda_i;

    assign rd_val = read_reg(ptr_q, low_setpoint_code_q, high_setpoint_code_q, ctl_q,
        soft_restart_trigger_q, restart_seen_q);

    // serial slave sequencing
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= bvc_pkg::BVC_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 4'h0;
            rd_q <= 1'b0;
            drive_low_q <= 1'b0;
            wr_stb_q <= 1'b0;
            wr_addr_q <= 4'h0;
            wr_data_q <= 8'h00;
            status_read_q <= 1'b0;
        end else begin
            wr_stb_q <= 1'b0;
            status_read_q <= 1'b0;
            if (start_seen) begin
                state_q <= bvc_pkg::BVC_ADDR;
                cnt_q <= 4'h0;
                drive_low_q <= 1'b0;
            end else if (stop_seen) begin
                state_q <= bvc_pkg::BVC_IDLE;
                drive_low_q <= 1'b0;
            end else begin
                case (state_q)
                    bvc_pkg::BVC_ADDR, bvc_pkg::BVC_REG, bvc_pkg::BVC_WDATA: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda_i};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == bvc_pkg::BITS_PER_BYTE) begin
                            cnt_q <= 4'h0;
                            if (state_q == bvc_pkg::BVC_ADDR) begin
                                if (sh_q[7:1] == bvc_pkg::DEV_ADDR) begin
                                    state_q <= bvc_pkg::BVC_ACK_ADDR;
                                    rd_q <= sh_q[0];
                                    drive_low_q <= 1'b1;
                                end else begin
                                    state_q <= bvc_pkg::BVC_IDLE;
                                end
                            end else if (state_q == bvc_pkg::BVC_REG) begin
                                state_q <= bvc_pkg::BVC_ACK_REG;
                                drive_low_q <= 1'b1;
                            end else begin
                                state_q <= bvc_pkg::BVC_ACK_WDATA;
                                drive_low_q <= 1'b1;
                            end
                        end
                    end
                    bvc_pkg::BVC_ACK_ADDR: begin
                        if (scl_fall) begin
                            if (rd_q) begin
                                state_q <= bvc_pkg::BVC_RDATA;
                                tx_q <= rd_val;
                                status_read_q <= (ptr_q == bvc_pkg::OFS_STATUS);
                                drive_low_q <= ~rd_val[7];
                                ptr_q <= ptr_q + 4'h1;
                            end else begin
                                state_q <= bvc_pkg::BVC_REG;
                                drive_low_q <= 1'b0;
                            end
                        end
                    end
                    bvc_pkg::BVC_ACK_REG: begin
                        if (scl_fall) begin
                            ptr_q <= sh_q[3:0];
                            state_q <= bvc_pkg::BVC_WDATA;
                            drive_low_q <= 1'b0;
                        end
                    end
                    bvc_pkg::BVC_ACK_WDATA: begin
                        if (scl_fall) begin
                            wr_stb_q <= 1'b1;
                            wr_addr_q <= ptr_q;
                            wr_data_q <= sh_q;
                            ptr_q <= ptr_q + 4'h1;
                            state_q <= bvc_pkg::BVC_WDATA;
                            drive_low_q <= 1'b0;
                        end
                    end
                    bvc_pkg::BVC_RDATA: begin
                        if (scl_rise) begin
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_q == bvc_pkg::BITS_PER_BYTE) begin
                                state_q <= bvc_pkg::BVC_ACK_RDATA;
                                drive_low_q <= 1'b0;
                                rd_q <= 1'b0;
                            end else begin
                                tx_q <= {tx_q[6:0], 1'b0};
                                drive_low_q <= ~tx_q[6];
                            end
                        end
                    end
                    bvc_pkg::BVC_ACK_RDATA: begin
                        if (scl_rise) begin
                            rd_q <= ~sda_i;
                            if (sda_i) begin
                                state_q <= bvc_pkg::BVC_IDLE;
                            end
                        end else if (scl_fall && rd_q) begin
                            state_q <= bvc_pkg::BVC_RDATA;
                            cnt_q <= 4'h0;
                            tx_q <= rd_val;
                            status_read_q <= (ptr_q == bvc_pkg::OFS_STATUS);
                            drive_low_q <= ~rd_val[7];
                            ptr_q <= ptr_q + 4'h1;
                        end
                    end
                    default: begin
                        drive_low_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign soft_reset = wr_stb_q && wr_addr_q == bvc_pkg::OFS_CTL_ONE
        && wr_data_q[bvc_pkg::BIT_SOFT_RESTART];

    // register bank
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            low_setpoint_code_q <= bvc_pkg::RST_SETPOINT;
            high_setpoint_code_q <= bvc_pkg::RST_SETPOINT;
            ctl_q <= bvc_pkg::RST_CTL_ONE;
        end else if (soft_reset) begin
            low_setpoint_code_q <= bvc_pkg::RST_SETPOINT;
            high_setpoint_code_q <= bvc_pkg::RST_SETPOINT;
            ctl_q <= bvc_pkg::RST_CTL_ONE;
        end else if (wr_stb_q) begin
            case (wr_addr_q)
                bvc_pkg::OFS_LOW_SEL: low_setpoint_code_q <= wr_data_q;
                bvc_pkg::OFS_HIGH_SEL: high_setpoint_code_q <= wr_data_q;
                bvc_pkg::OFS_CTL_ONE: ctl_q <= wr_data_q & bvc_pkg::CTL_WRITE_MASK;
                default: ctl_q <= ctl_q;
            endcase
        end
    end

    // self-clearing trigger and restart flag, set wins over read clear
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            soft_restart_trigger_q <= 1'b0;
            restart_seen_q <= 1'b0;
        end else begin
            soft_restart_trigger_q <= soft_reset;
            if (soft_reset) begin
                restart_seen_q <= 1'b1;
            end else if (status_read_q) begin
                restart_seen_q <= 1'b0;
            end
        end
    end

    assign rif.target_code = level_sel ? high_setpoint_code_q : low_setpoint_code_q;
    assign rif.rise_slew_code = ctl_q[bvc_pkg::BIT_SLEW_HI:bvc_pkg::BIT_SLEW_LO];

    // converter-facing outputs and serial data output
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cont_pwm_q <= 1'b0;
            discharge_q <= 1'b0;
            applied_q <= bvc_pkg::RST_SETPOINT;
            rising_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            cont_pwm_q <= level_sel ? ctl_q[bvc_pkg::BIT_HIGH_MODE]
                : ctl_q[bvc_pkg::BIT_LOW_MODE];
            discharge_q <= ctl_q[bvc_pkg::BIT_DISCHARGE];
            applied_q <= rif.applied_code;
            rising_q <= rif.rising;
            sda_out_q <= 1'b0;
        end
    end

    assign sda_o = sda_out_q;
    assign sda_oe_b = ~drive_low_q;
    assign applied_code = applied_q;
    assign rise_active = rising_q;
    assign cont_pwm = cont_pwm_q;
    assign discharge_en = discharge_q;
    assign restart_seen = restart_seen_q;
endmodule

//--- bench/bvc_props.sv
`timescale 1ns/1ps
module bvc_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_b,
    input wire logic level_sel,
    input wire logic [7:0] applied_code,
    input wire logic rise_active,
    input wire logic cont_pwm,
    input wire logic discharge_en,
    input wire logic restart_seen
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_reset_code;
        $rose(rst_b) |-> (applied_code == 8'h14) [*6];
    endproperty
    a_reset_code: assert property (p_reset_code) else $error("reset code");
    property p_reset_ctl;
        $rose(rst_b) |-> ##[2:8] (discharge_en && cont_pwm == level_sel);
    endproperty
    a_reset_ctl: assert property (p_reset_ctl) else $error("reset control");
    property p_step_one;
        (applied_code > $past(applied_code)) |-> applied_code == $past(applied_code) + 8'h01;
    endproperty
    a_step_one: assert property (p_step_one) else $error("rise step size");
    property p_step_hold;
        (applied_code == $past(applied_code) + 8'h01) |=>
            (applied_code <= $past(applied_code)) [*2];
    endproperty
    a_step_hold: assert property (p_step_hold) else $error("rise step too fast");
    property p_rise_flag;
        (applied_code > $past(applied_code)) |-> rise_active || $past(rise_active);
    endproperty
    a_rise_flag: assert property (p_rise_flag) else $error("rise flag");
    property p_restart_ctl;
        $rose(restart_seen) |-> ##[0:3] discharge_en;
    endproperty
    a_restart_ctl: assert property (p_restart_ctl) else $error("restart control");
    property p_sda_move;
        $changed(sda_oe_b) |-> !scl_i;
    endproperty
    a_sda_move: assert property (p_sda_move) else $error("data moved, clock high");
    property p_sda_zero;
        !sda_oe_b |-> sda_o == 1'b0;
    endproperty
    a_sda_zero: assert property (p_sda_zero) else $error("data driven high");
endmodule

//--- bench/bvc_host_model.sv
`timescale 1ns/1ps
module bvc_host_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic hp();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda = b;
        hp();
        scl = 1'b1;
        hp();
        r = sda_line;
        scl = 1'b0;
    endtask
    task automatic start();
        sda = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda = 1'b0;
        hp();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda = 1'b1;
        hp();
    endtask
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
        output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(last, a);
    endtask
endmodule

//--- bench/buck_voltage_control_regs_bench.sv
`timescale 1ns/1ps
module buck_voltage_control_regs_bench;
    logic clk;
    logic rst_b = 1'b0;
    logic level_sel = 1'b0;
    logic scl, sda_h, sda_line, sda_o, sda_oe_b, rise_active, cont_pwm, discharge_en;
    logic restart_seen;
    logic [7:0] applied_code;
    logic [7:0] d;
    int n_mismatch = 0;
    int checks = 0;
    localparam logic [7:0] PROD = {bvc_pkg::PRODUCT_FIXED, bvc_pkg::PRODUCT_CODE};
    assign sda_line = sda_h & (sda_oe_b | sda_o);
    bvc_top u_bvc_top (.clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_b(sda_oe_b), .level_sel(level_sel),
        .applied_code(applied_code), .rise_active(rise_active), .cont_pwm(cont_pwm),
        .discharge_en(discharge_en), .restart_seen(restart_seen));
    bvc_host_model u_bvc_host_model (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda_h));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] r, input logic [7:0] v);
        logic [7:0] x;
        logic a;
        u_bvc_host_model.start();
        u_bvc_host_model.xfer({bvc_pkg::DEV_ADDR, 1'b0}, 1'b1, x, a);
        u_bvc_host_model.xfer({4'h0, r}, 1'b1, x, a);
        u_bvc_host_model.xfer(v, 1'b1, x, a);
        chk_bit("ack", 1'b0, a);
        u_bvc_host_model.stop();
    endtask
    task automatic rd(input logic [3:0] r, output logic [7:0] v);
        logic [7:0] x;
        logic a;
        u_bvc_host_model.start();
        u_bvc_host_model.xfer({bvc_pkg::DEV_ADDR, 1'b0}, 1'b1, x, a);
        u_bvc_host_model.xfer({4'h0, r}, 1'b1, x, a);
        u_bvc_host_model.start();
        u_bvc_host_model.xfer({bvc_pkg::DEV_ADDR, 1'b1}, 1'b1, x, a);
        u_bvc_host_model.xfer(8'hFF, 1'b1, v, a);
        u_bvc_host_model.stop();
    endtask
    task automatic settle(input logic [7:0] e, input int lo, input int hi);
        int n = 0;
        while (applied_code !== e && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_bit("ramp time", 1'b1, n >= lo && n <= hi);
        repeat (3) @(posedge clk);
        #1;
        chk_byte("applied_code", e, applied_code);
        chk_bit("rise_active", 1'b0, rise_active);
    endtask
    task automatic t_defaults();
        logic [7:0] e [5];
        e = '{8'h14, 8'h14, 8'h92, PROD, {bvc_pkg::REVISION_FIXED, bvc_pkg::REVISION_CODE}};
        for (int i = 0; i < 5; i++) begin
            rd(4'(i), d);
            chk_byte("reg", e[i], d);
        end
        rd(4'h7, d);
        chk_byte("unmapped", 8'h00, d);
        chk_bit("discharge_en", 1'b1, discharge_en);
        $display("done defaults");
    endtask
    task automatic t_ramp();
        wr(4'h0, 8'h1E);
        chk_bit("rise_active", 1'b1, rise_active);
        settle(8'h1E, 30, 60);
        rd(4'h0, d);
        chk_byte("low_sel", 8'h1E, d);
        $display("done ramp");
    endtask
    task automatic t_select();
        wr(4'h1, 8'hA0);
        chk_byte("applied_code", 8'h1E, applied_code);
        level_sel = 1'b1;
        settle(8'hA0, 648, 656);
        chk_bit("cont_pwm", 1'b1, cont_pwm);
        level_sel = 1'b0;
        settle(8'h1E, 0, 5);
        chk_bit("cont_pwm", 1'b0, cont_pwm);
        $display("done select");
    endtask
    task automatic t_modes();
        wr(4'h2, 8'h09);
        rd(4'h2, d);
        chk_byte("ctl", 8'h01, d);
        chk_bit("discharge_en", 1'b0, discharge_en);
        chk_bit("cont_pwm", 1'b1, cont_pwm);
        level_sel = 1'b1;
        settle(8'hA0, 385, 405);
        chk_bit("cont_pwm", 1'b0, cont_pwm);
        level_sel = 1'b0;
        settle(8'h1E, 0, 5);
        $display("done modes");
    endtask
    task automatic t_restart();
        wr(4'h2, 8'h04);
        chk_bit("restart_seen", 1'b1, restart_seen);
        rd(4'h2, d);
        chk_byte("ctl", 8'h92, d);
        rd(4'h1, d);
        chk_byte("high_sel", 8'h14, d);
        chk_byte("applied_code", 8'h14, applied_code);
        rd(4'h5, d);
        chk_byte("status", 8'h04, d);
        chk_bit("restart_seen", 1'b0, restart_seen);
        wr(4'h3, 8'h00);
        rd(4'h3, d);
        chk_byte("product", PROD, d);
        $display("done restart");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        t_defaults();
        t_ramp();
        t_select();
        t_modes();
        t_restart();
        test_done();
    end
endmodule
bind bvc_top bvc_props u_bvc_props (.clk(clk), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_b(sda_oe_b), .level_sel(level_sel), .applied_code(applied_code),
    .rise_active(rise_active), .cont_pwm(cont_pwm), .discharge_en(discharge_en),
    .restart_seen(restart_seen));
